// ===== hw/eenv_top.sv
// eeprom and boot configuration latches behind an avalon-mm slave
// How it works
// - Any of the 2048 eeprom bytes is read directly with no command.
// - Eeprom is written only through the row command register.
// - Eeprom programming never stalls the bus or the processor.
// - Eeprom is 128 rows of 16 bytes, erased and written by row.
// - Eeprom has no hardware ecc and is not an instruction source.
// - Four config latch bytes configure the device on reset exit.
// - Drive mode codes: analog hi-z, digital hi-z, pull up, pull down.
// - A port's drive mode is applied alike to all its pins.
// - The reset select bit makes the shared pin gpio (0) or reset (1).
// - The debug enable bit blocks (0) or allows (1) debug access.
// - The boot speed bit picks a 12 MHz (0) or 48 MHz (1) boot clock.
// - The ecc bit makes the extra flash hold ecc (1) or data (0).
// - A 4-bit latch field selects the digital clock phase delay.
//
// The Avalon-MM slave port was decided locally.
`default_nettype none

module eenv_top
  import eenv_pkg::*;
#(
  parameter int       WRITE_CYCLES = EE_WRITE_CYCLES,
  parameter bit       RPIN_DEFAULT = 1'b0
) (
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic [15:0]                    avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  output logic                                ee_busy,
  output logic      [NUM_PORTS*PORT_PINS-1:0] pin_dig_en,
  output logic      [NUM_PORTS*PORT_PINS-1:0] pin_pull_up,
  output logic      [NUM_PORTS*PORT_PINS-1:0] pin_pull_down,
  output logic                                shared_pin_is_reset,
  output logic                                debug_access_enable,
  output logic                                debug_port_jtag5,
  output logic                                debug_port_jtag4,
  output logic                                debug_port_swd,
  output logic                                ecc_flash_enable,
  output logic                                boot_clock_speed,
  output logic      [3:0]                     digital_clock_phase_delay
);

  // ************************************************************
  // factory defaults of the latch array
  // ************************************************************
  localparam logic [7:0] DEF_RST_DBG_X =
    DEF_RST_DBG | {RPIN_DEFAULT, 7'h00};
  localparam logic [31:0] CFG_DEFAULTS =
    {DEF_BOOT, DEF_RST_DBG_X, DEF_PORT_HI, DEF_PORT_LO};

  // ************************************************************
  // storage
  // ************************************************************
  // nonvolatile: survives rst_n, starts at the factory values
  logic [7:0] latch_reg [NUM_LATCHES] = '{
    DEF_PORT_LO, DEF_PORT_HI, DEF_RST_DBG_X, DEF_BOOT
  };
  logic [7:0]              buf_reg [EE_ROW_BYTES];
  logic                    cfg_loaded_reg;
  logic [1:0]              rd_stage_reg;
  logic [31:0]             rdata_reg;
  logic                    done_reg;
  logic                    store_rej_reg;
  logic                    cmd_ref_reg;

  // ************************************************************
  // address decode
  // ************************************************************
  wire logic hit_latch  = (avs_address & LATCH_MASK) == LATCH_BASE;
  wire logic hit_cmd    = (avs_address == OFF_CMD);
  wire logic hit_status = (avs_address == OFF_STATUS);
  wire logic hit_active = (avs_address == OFF_ACTIVE);
  wire logic hit_buf    = (avs_address & BUF_MASK) == BUF_BASE;
  wire logic hit_ee     = (avs_address & EE_MASK) == EE_BASE;

  wire logic [1:0]          latch_idx = avs_address[3:2];
  wire logic [EE_COL_W-1:0] buf_idx   = avs_address[EE_COL_W+1:2];
  wire logic [EE_IDX_W-1:0] ee_idx    = avs_address[EE_IDX_W+1:2];

  wire logic lane0  = avs_byteenable[0];
  wire logic lane1  = avs_byteenable[1];
  wire logic wr_ok  = avs_write && !avs_read;

  wire logic wr_latch  = wr_ok && hit_latch && lane0;
  wire logic wr_buf    = wr_ok && hit_buf && lane0;
  wire logic wr_cmd    = wr_ok && hit_cmd && lane1;
  wire logic wr_status = wr_ok && hit_status && lane0;
  // stores into the eeprom window are refused, data untouched
  wire logic wr_ee     = wr_ok && hit_ee;

  wire logic cmd_write = avs_writedata[CMD_WRITE_BIT];
  wire logic cmd_erase = avs_writedata[CMD_ERASE_BIT];
  wire logic [EE_ROW_W-1:0] cmd_row = avs_writedata[EE_ROW_W-1:0];

  // erase wins when both bits are set
  wire logic cmd_any     = wr_cmd && (cmd_write || cmd_erase);
  wire logic prog_busy;
  wire logic prog_done;
  wire logic prog_start  = cmd_any && !prog_busy;
  wire logic prog_refuse = cmd_any && prog_busy;

  // ************************************************************
  // eeprom array and program engine
  // ************************************************************
  logic [EE_ROW_BYTES*8-1:0] buf_flat;
  logic [7:0]                ee_rd_data;

  for (genvar i = 0; i < EE_ROW_BYTES; i++) begin : g_flat
    assign buf_flat[i*8 +: 8] = buf_reg[i];
  end

  eenv_eeprom #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_eeprom (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .rd_index   (ee_idx),
    .rd_data    (ee_rd_data),
    .prog_start (prog_start),
    .prog_erase (cmd_erase),
    .prog_row   (cmd_row),
    .prog_data  (buf_flat),
    .busy       (prog_busy),
    .done       (prog_done)
  );

  assign ee_busy = prog_busy;

  // ************************************************************
  // config latches and boot capture
  // ************************************************************
  // new latch values only take effect at the next reset
  always_ff @(posedge mclk) begin
    if (wr_latch) latch_reg[latch_idx] <= avs_writedata[7:0];
  end

  wire logic [31:0] latch_vec =
    {latch_reg[LATCH_BOOT], latch_reg[LATCH_RST_DBG],
     latch_reg[LATCH_PORT_HI], latch_reg[LATCH_PORT_LO]};

  always_ff @(posedge mclk) begin
    if (!rst_n) cfg_loaded_reg <= 1'b0;
    else cfg_loaded_reg <= 1'b1;
  end

  wire logic        cfg_load = !cfg_loaded_reg;
  logic      [31:0] active;

  eenv_cfg_apply #(
    .DEFAULTS (CFG_DEFAULTS)
  ) u_cfg (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .load          (cfg_load),
    .latch_vec     (latch_vec),
    .active        (active),
    .pin_dig_en    (pin_dig_en),
    .pin_pull_up   (pin_pull_up),
    .pin_pull_down (pin_pull_down)
  );

  // ************************************************************
  // settings derived from the captured latches
  // ************************************************************
  wire eenv_dbgport_t dport = eenv_dbgport_t'(active[DPORT_LSB +: 2]);

  assign shared_pin_is_reset = active[RPIN_SEL_BIT];
  assign debug_access_enable = active[DBG_EN_BIT];
  assign boot_clock_speed    = active[BOOT_SPD_BIT];
  assign debug_port_jtag5    = debug_access_enable && (dport == DP_JTAG5);
  assign debug_port_jtag4    = debug_access_enable && (dport == DP_JTAG4);
  assign debug_port_swd      = debug_access_enable && (dport == DP_SWD);
  // DP_NONE leaves all three port selects low
  assign ecc_flash_enable    = active[ECC_EN_BIT];
  assign digital_clock_phase_delay = active[PHS_LSB +: 4];

  // ************************************************************
  // row buffer and status flags
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < EE_ROW_BYTES; i++) buf_reg[i] <= EE_ERASED_BYTE;
    end else if (wr_buf) begin
      buf_reg[buf_idx] <= avs_writedata[7:0];
    end
  end

  // write one to clear; a new event in the same cycle wins
  wire logic clr_done = wr_status && avs_writedata[ST_DONE];
  wire logic clr_rej  = wr_status && avs_writedata[ST_STORE_REJ];
  wire logic clr_ref  = wr_status && avs_writedata[ST_CMD_REF];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      done_reg      <= 1'b0;
      store_rej_reg <= 1'b0;
      cmd_ref_reg   <= 1'b0;
    end else begin
      done_reg      <= prog_done || (done_reg && !clr_done);
      store_rej_reg <= wr_ee || (store_rej_reg && !clr_rej);
      cmd_ref_reg   <= prog_refuse || (cmd_ref_reg && !clr_ref);
    end
  end

  wire logic [31:0] status_word =
    32'(prog_busy)     << ST_BUSY |
    32'(done_reg)      << ST_DONE |
    32'(store_rej_reg) << ST_STORE_REJ |
    32'(cmd_ref_reg)   << ST_CMD_REF;

  // ************************************************************
  // read path: two wait cycles, then registered data
  // ************************************************************
  // raw array bytes come back unchecked, no ecc
  wire logic [31:0] rd_mux =
    hit_latch  ? {24'h000000, latch_reg[latch_idx]} :
    hit_status ? status_word :
    hit_active ? active :
    hit_buf    ? {24'h000000, buf_reg[buf_idx]} :
    hit_ee     ? {24'h000000, ee_rd_data} :
                 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_stage_reg <= 2'h0;
      rdata_reg    <= 32'h00000000;
    end else if (avs_read && !avs_write) begin
      rd_stage_reg <= (rd_stage_reg == 2'h2) ? 2'h0 : rd_stage_reg + 2'h1;
      if (rd_stage_reg == 2'h1) rdata_reg <= rd_mux;
    end else begin
      rd_stage_reg <= 2'h0;
    end
  end

  assign avs_readdata = rdata_reg;
  // writes finish at once, even while a row is being programmed
  assign avs_waitrequest = avs_read && !avs_write && (rd_stage_reg != 2'h2);

endmodule // eenv_top

`default_nettype wire

// ===== hw/eenv_pkg.sv
// shared constants, types and decode functions for the eeprom/config block
`default_nettype none

package eenv_pkg;

  // ************************************************************
  // eeprom geometry
  // ************************************************************
  localparam int EE_ROWS      = 128;
  localparam int EE_ROW_BYTES = 16;
  localparam int EE_BYTES     = EE_ROWS * EE_ROW_BYTES;
  localparam int EE_ROW_W     = 7;
  localparam int EE_COL_W     = 4;
  localparam int EE_IDX_W     = 11;
  localparam logic [7:0] EE_ERASED_BYTE = 8'hFF;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ         = 100;
  localparam int EE_WRITE_MS     = 20;
  localparam int EE_WRITE_CYCLES = EE_WRITE_MS * 1000 * CLK_MHZ;
  localparam int EE_CNT_W        = 32;

  // ************************************************************
  // byte addresses on the register bus
  // ************************************************************
  localparam logic [15:0] LATCH_MASK = 16'hFFF0;
  localparam logic [15:0] LATCH_BASE = 16'h0000;
  localparam logic [15:0] OFF_CMD    = 16'h0010;
  localparam logic [15:0] OFF_STATUS = 16'h0014;
  localparam logic [15:0] OFF_ACTIVE = 16'h0018;
  localparam logic [15:0] BUF_MASK   = 16'hFFC0;
  localparam logic [15:0] BUF_BASE   = 16'h0040;
  localparam logic [15:0] EE_MASK    = 16'hE000;
  localparam logic [15:0] EE_BASE    = 16'h2000;

  // config latch indices (byte address is four times the index)
  localparam logic [1:0] LATCH_PORT_LO = 2'h0;
  localparam logic [1:0] LATCH_PORT_HI = 2'h1;
  localparam logic [1:0] LATCH_RST_DBG = 2'h2;
  localparam logic [1:0] LATCH_BOOT    = 2'h3;
  localparam int NUM_LATCHES = 4;

  // ************************************************************
  // latch field positions, in the flat 32-bit latch vector
  // ************************************************************
  localparam int NUM_PORTS     = 9;
  localparam int PORT_PINS     = 8;
  localparam int RPIN_SEL_BIT  = 23;
  localparam int DBG_EN_BIT    = 22;
  localparam int BOOT_SPD_BIT  = 24;
  localparam int DPORT_LSB     = 25;
  localparam int ECC_EN_BIT    = 27;
  localparam int PHS_LSB       = 28;

  localparam logic [7:0] DEF_PORT_LO = 8'h00;
  localparam logic [7:0] DEF_PORT_HI = 8'h00;
  localparam logic [7:0] DEF_RST_DBG = 8'h40;
  localparam logic [7:0] DEF_BOOT    = 8'h0A;

  // ************************************************************
  // command and status bits
  // ************************************************************
  localparam int CMD_WRITE_BIT = 8;
  localparam int CMD_ERASE_BIT = 9;
  localparam int ST_BUSY       = 0;
  localparam int ST_DONE       = 1;
  localparam int ST_STORE_REJ  = 2;
  localparam int ST_CMD_REF    = 3;

  typedef enum logic [1:0] {
    DRV_HIZ_ANALOG  = 2'h0,
    DRV_HIZ_DIGITAL = 2'h1,
    DRV_PULL_UP     = 2'h2,
    DRV_PULL_DOWN   = 2'h3
  } eenv_drive_t;

  typedef enum logic [1:0] {
    DP_JTAG5 = 2'h0,
    DP_JTAG4 = 2'h1,
    DP_SWD   = 2'h2,
    DP_NONE  = 2'h3
  } eenv_dbgport_t;

  typedef enum logic [1:0] {
    PG_IDLE   = 2'b00,
    PG_BUSY   = 2'b01,
    PG_COMMIT = 2'b11
  } eenv_prog_t;

  // {digital input enable, pull up, pull down}
  function automatic logic [2:0] eenv_drive_decode(input logic [1:0] m);
    unique case (eenv_drive_t'(m))
      DRV_HIZ_ANALOG:  return 3'h0;
      DRV_HIZ_DIGITAL: return 3'h4;
      DRV_PULL_UP:     return 3'h6;
      DRV_PULL_DOWN:   return 3'h5;
    endcase
  endfunction

endpackage

`default_nettype wire

// ===== hw/eenv_eeprom.sv
// eeprom byte array with a row-wide timed program engine
`default_nettype none

module eenv_eeprom
  import eenv_pkg::*;
#(
  parameter int WRITE_CYCLES = EE_WRITE_CYCLES
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [EE_IDX_W-1:0]       rd_index,
  output logic      [7:0]                rd_data,
  input  wire logic                      prog_start,
  input  wire logic                      prog_erase,
  input  wire logic [EE_ROW_W-1:0]       prog_row,
  input  wire logic [EE_ROW_BYTES*8-1:0] prog_data,
  output logic                           busy,
  output logic                           done
);

  localparam logic [EE_CNT_W-1:0] LAST_CNT = EE_CNT_W'(WRITE_CYCLES - 1);

  logic [7:0]                mem [EE_BYTES];
  eenv_prog_t                state_reg;
  logic [EE_CNT_W-1:0]       cnt_reg;
  logic [EE_ROW_W-1:0]       row_reg;
  logic                      erase_reg;
  logic [EE_ROW_BYTES*8-1:0] data_reg;

  wire logic cnt_end = (cnt_reg == LAST_CNT);

  assign busy = (state_reg != PG_IDLE);
  assign done = (state_reg == PG_COMMIT);

  // ************************************************************
  // program engine: whole row at once, after the full write time
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= PG_IDLE;
      cnt_reg   <= '0;
      row_reg   <= '0;
      erase_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      unique case (state_reg)
        PG_IDLE: if (prog_start) begin
          state_reg <= PG_BUSY;
          cnt_reg   <= '0;
          row_reg   <= prog_row;
          erase_reg <= prog_erase;
          data_reg  <= prog_data; // engine owns a copy, buffer reusable
        end
        PG_BUSY: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_end) state_reg <= PG_COMMIT;
        end
        PG_COMMIT: state_reg <= PG_IDLE;
        default: state_reg <= PG_IDLE;
      endcase
    end
  end

  // no ecc bits are stored or checked, bytes are raw
  always_ff @(posedge mclk) begin
    if (state_reg == PG_COMMIT) begin
      for (int i = 0; i < EE_ROW_BYTES; i++) begin
        mem[{row_reg, EE_COL_W'(i)}] <= erase_reg ? EE_ERASED_BYTE
                                                  : data_reg[i*8 +: 8];
      end
    end
  end

  // reads never wait for the engine
  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_index];
  end

endmodule // eenv_eeprom

`default_nettype wire

// ===== hw/eenv_cfg_apply.sv
// boot configuration: captures the latches once and drives the settings
`default_nettype none

module eenv_cfg_apply
  import eenv_pkg::*;
#(
  parameter logic [31:0] DEFAULTS = 32'h0A400000
) (
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic                           load,
  input  wire logic [31:0]                    latch_vec,
  output logic      [31:0]                    active,
  output logic      [NUM_PORTS*PORT_PINS-1:0] pin_dig_en,
  output logic      [NUM_PORTS*PORT_PINS-1:0] pin_pull_up,
  output logic      [NUM_PORTS*PORT_PINS-1:0] pin_pull_down
);

  always_ff @(posedge mclk) begin
    if (!rst_n) active <= DEFAULTS;
    else if (load) active <= latch_vec;
  end

  // one mode per port, fanned out to all its pins
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    wire logic [2:0] drv = eenv_drive_decode(active[2*p +: 2]);
    for (genvar b = 0; b < PORT_PINS; b++) begin : g_pin
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pin_dig_en[p*PORT_PINS+b]    <= 1'b0;
          pin_pull_up[p*PORT_PINS+b]   <= 1'b0;
          pin_pull_down[p*PORT_PINS+b] <= 1'b0;
        end else begin
          pin_dig_en[p*PORT_PINS+b]    <= drv[2];
          pin_pull_up[p*PORT_PINS+b]   <= drv[1];
          pin_pull_down[p*PORT_PINS+b] <= drv[0];
        end
      end
    end
  end

endmodule // eenv_cfg_apply

`default_nettype wire

// ===== tb/eenv_checker.sv
// port-level assertions for the eeprom and boot config block
`default_nettype none

module eenv_checker
  import eenv_pkg::*;
#(
  parameter int WRITE_CYCLES = 12
) (
  input wire logic                           mclk,
  input wire logic                           rst_n,
  input wire logic [15:0]                    avs_address,
  input wire logic                           avs_read,
  input wire logic                           avs_write,
  input wire logic [31:0]                    avs_writedata,
  input wire logic [3:0]                     avs_byteenable,
  input wire logic [31:0]                    avs_readdata,
  input wire logic                           avs_waitrequest,
  input wire logic                           ee_busy,
  input wire logic [NUM_PORTS*PORT_PINS-1:0] pin_dig_en,
  input wire logic [NUM_PORTS*PORT_PINS-1:0] pin_pull_up,
  input wire logic [NUM_PORTS*PORT_PINS-1:0] pin_pull_down,
  input wire logic                           shared_pin_is_reset,
  input wire logic                           debug_access_enable,
  input wire logic                           debug_port_jtag5,
  input wire logic                           debug_port_jtag4,
  input wire logic                           debug_port_swd,
  input wire logic                           ecc_flash_enable,
  input wire logic                           boot_clock_speed,
  input wire logic [3:0]                     digital_clock_phase_delay
);
  // ********
  // helpers
  // ********
  logic [31:0] busy_cnt_reg;

  function automatic logic uniform(input logic [71:0] v);
    uniform = 1'b1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (v[p*8+:8] != 8'h00 && v[p*8+:8] != 8'hFF) uniform = 1'b0;
    end
  endfunction

  wire uni_w = uniform(pin_dig_en) & uniform(pin_pull_up)
             & uniform(pin_pull_down);
  wire [226:0] cfg_w = {pin_dig_en, pin_pull_up, pin_pull_down,
    shared_pin_is_reset, debug_access_enable, debug_port_jtag5,
    debug_port_jtag4, debug_port_swd, ecc_flash_enable, boot_clock_speed,
    digital_clock_phase_delay};

  // counts busy edges so the program time can be checked exactly
  always_ff @(posedge mclk) begin
    if (!rst_n || !ee_busy) busy_cnt_reg <= 32'h0;
    else busy_cnt_reg <= busy_cnt_reg + 32'h1;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ********
  // assertions
  // ********
  AST_NO_WAIT: assert property (!avs_read |-> !avs_waitrequest)
    else $error("waitrequest high without a read");
  AST_READ_WAIT: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not in third cycle");
  AST_BUSY_START: assert property (avs_write && !ee_busy &&
    avs_address == OFF_CMD && avs_byteenable[1] &&
    (avs_writedata[8] || avs_writedata[9]) |=> ee_busy)
    else $error("row command did not start programming");
  AST_BUSY_LEN: assert property ($fell(ee_busy) |->
    busy_cnt_reg == WRITE_CYCLES + 1)
    else $error("program time wrong");
  AST_BUSY_MAX: assert property (busy_cnt_reg <= WRITE_CYCLES + 1)
    else $error("programming overran");
  AST_DBG_GATE: assert property (!debug_access_enable |->
    !(debug_port_jtag5 || debug_port_jtag4 || debug_port_swd))
    else $error("debug port active while debug disabled");
  AST_DP_ONE: assert property ($onehot0({debug_port_jtag5,
    debug_port_jtag4, debug_port_swd}))
    else $error("more than one debug port selected");
  AST_UNIFORM: assert property (uni_w)
    else $error("pins of one port differ");
  AST_DRIVE: assert property (
    (pin_pull_up & pin_pull_down) == '0 &&
    ((pin_pull_up | pin_pull_down) & ~pin_dig_en) == '0)
    else $error("illegal pin drive combination");
  AST_CFG_HOLD: assert property ($past(rst_n) &&
    $past(rst_n, 2) && $past(rst_n, 3) |-> $stable(cfg_w))
    else $error("config outputs changed outside reset");

endmodule // eenv_checker

bind eenv_top eenv_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ee_busy(ee_busy), .pin_dig_en(pin_dig_en), .pin_pull_up(pin_pull_up),
  .pin_pull_down(pin_pull_down), .shared_pin_is_reset(shared_pin_is_reset),
  .debug_access_enable(debug_access_enable),
  .debug_port_jtag5(debug_port_jtag5), .debug_port_jtag4(debug_port_jtag4),
  .debug_port_swd(debug_port_swd), .ecc_flash_enable(ecc_flash_enable),
  .boot_clock_speed(boot_clock_speed),
  .digital_clock_phase_delay(digital_clock_phase_delay));

`default_nettype wire

// ===== tb/tb_top.sv
// randomised self-checking bench for the eeprom and boot config block
`default_nettype none

module tb_top
  import eenv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 12;

  // ********
  // signals
  // ********
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, ee_busy, shared_pin_is_reset;
  logic [71:0] pin_dig_en, pin_pull_up, pin_pull_down;
  logic        debug_access_enable, debug_port_jtag5, debug_port_jtag4;
  logic        debug_port_swd, ecc_flash_enable, boot_clock_speed;
  logic [3:0]  digital_clock_phase_delay;
  int          fails = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h0000004D;
  logic [31:0] q, v, vprev;
  logic [7:0]  dat [16];
  logic [6:0]  row;
  logic        ers;
  wire  [10:0] cfg_now = {digital_clock_phase_delay, ecc_flash_enable,
    debug_port_jtag5, debug_port_jtag4, debug_port_swd, boot_clock_speed,
    shared_pin_is_reset, debug_access_enable};

  always #5 mclk = ~mclk;

  eenv_top #(.WRITE_CYCLES(WC), .RPIN_DEFAULT(1'b0)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ee_busy(ee_busy), .pin_dig_en(pin_dig_en), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .shared_pin_is_reset(shared_pin_is_reset),
    .debug_access_enable(debug_access_enable),
    .debug_port_jtag5(debug_port_jtag5), .debug_port_jtag4(debug_port_jtag4),
    .debug_port_swd(debug_port_swd), .ecc_flash_enable(ecc_flash_enable),
    .boot_clock_speed(boot_clock_speed),
    .digital_clock_phase_delay(digital_clock_phase_delay));

  // ********
  // helpers
  // ********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // k: 0 digital enable, 1 pull up, 2 pull down
  function automatic logic [71:0] pins(input logic [31:0] c,
                                       input logic [1:0] k);
    logic [1:0] m;
    pins = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      m = c[2*p+:2];
      pins[p*8+:8] = {8{k == 2'h0 ? m != 2'h0 : m == k + 2'h1}};
    end
  endfunction

  function automatic logic [10:0] cfg_exp(input logic [31:0] c);
    logic [2:0] dp;
    dp = c[22] ? 3'h4 >> c[26:25] : 3'h0;
    return {c[31:28], c[27], dp, c[24], c[23], c[22]};
  endfunction

  task automatic chk(input string nm, input logic [71:0] got,
                     input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) fails++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic do_reset(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge mclk);
    chk("reset cfg", 72'(cfg_now), 72'h051);
    chk("reset pins", pin_dig_en | pin_pull_up | pin_pull_down,
        72'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic cfg_check(input logic [31:0] c);
    chk("dig_en", pin_dig_en, pins(c, 2'h0));
    chk("pull_up", pin_pull_up, pins(c, 2'h1));
    chk("pull_down", pin_pull_down, pins(c, 2'h2));
    chk("cfg", 72'(cfg_now),
        72'(cfg_exp(c)));
    bus(1'b0, OFF_ACTIVE, 32'h0, 4'hF);
    chk("active", 72'(q), 72'(c));
  endtask

  task automatic results();
    $display("tests %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial begin
    do_reset(8);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      v[26:25] = i[1:0];
      if (i == 0) v[15:0] = 16'h1BE4;
      if (i == 4) v[22] = 1'b0;
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, 16'(k * 4), {24'h0, v[k*8+:8]}, 4'h1);
        bus(1'b0, 16'(k * 4), 32'h0, 4'h1);
        chk("latch", 72'(q), 72'(v[k*8+:8]));
      end
      if (i > 0) cfg_check(vprev);
      do_reset(2);
      cfg_check(v);
      vprev = v;
      $display("test cfg %0d done", i);
    end
    for (int j = 0; j < 3; j++) begin
      if (j == 0) row = 7'h7F;
      if (j == 1) row = 7'(rnd());
      ers = (j == 2);
      for (int b = 0; b < 16; b++) begin
        dat[b] = 8'(rnd());
        bus(1'b1, BUF_BASE + 16'(b * 4), {24'h0, dat[b]}, 4'h1);
      end
      bus(1'b1, OFF_STATUS, 32'h0000000F, 4'h1);
      bus(1'b1, OFF_CMD, {22'h0, ers, !ers, 1'b0, row}, 4'h3);
      bus(1'b1, OFF_CMD, 32'h00000100, 4'h3);
      bus(1'b1, EE_BASE | {3'h0, row, 4'h0, 2'h0}, 32'h0, 4'h1);
      bus(1'b0, OFF_STATUS, 32'h0, 4'h1);
      chk("status busy", 72'(q), 72'hD);
      for (int t = 0; t < 100 && ee_busy !== 1'b0; t++)
        @(posedge mclk);
      bus(1'b0, OFF_STATUS, 32'h0, 4'h1);
      chk("status done", 72'(q), 72'hE);
      for (int b = 0; b < 16; b++) begin
        bus(1'b0, EE_BASE | {3'h0, row, 4'(b), 2'h0}, 32'h0, 4'hF);
        chk("ee byte", 72'(q),
            72'(ers ? 8'hFF : dat[b]));
      end
      $display("test row %0d done", j);
    end
    bus(1'b1, 16'h0030, 32'h000000FF, 4'hF);
    bus(1'b0, 16'h0030, 32'h0, 4'hF);
    chk("unmapped", 72'(q), 72'h0);
    $display("test map done");
    results();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    results();
  end

endmodule // tb_top

`default_nettype wire
